// ---- rtc_alarm_field.sv ----
`timescale 1ns/1ps
`default_nettype none

// One alarm compare field with its don't-care code
module rtc_alarm_field
	import rtc_pkg::*;
(
	input  wire logic [7:0] count,
	input  wire logic [7:0] alarm,
	output logic            hit
);
	// Both top bits set matches any count
	assign hit = (alarm[7:6] == ALARM_ANY) || (alarm == count); // [RULE_03]
endmodule

`default_nettype wire

// ---- rtc_count_step.sv ----
`timescale 1ns/1ps
`default_nettype none

// Next value of one wrapping counter, in the selected number format
module rtc_count_step
	import rtc_pkg::*;
(
	input  wire logic [7:0] cur,
	input  wire logic [6:0] lo,
	input  wire logic [6:0] hi,
	input  wire logic       bcd,
	output logic      [7:0] nxt,
	output logic            wrap
);
	logic [6:0] bin;

	// Out-of-range values also roll over so a bad write cannot stall the counter
	always_comb
	begin
		bin  = to_bin(cur, bcd);
		wrap = (bin >= hi);
		nxt  = wrap ? from_bin(lo, bcd) : from_bin(7'(bin + 7'd1), bcd);
	end
endmodule

`default_nettype wire

// ---- rtc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtc_host_model
	import rtc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic [7:0] host_rdata_q,
	output var logic        host_sel,
	output var logic        host_wr,
	output var logic        host_rd,
	output var logic  [7:0] host_wdata
);
	// Idle host port
	initial
	begin
		host_sel = PORT_INDEX;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_wdata = 8'h00;
	end

	// Index write always comes first
	task automatic put_index(input logic [6:0] idx);
		@(posedge ref_clk);
		host_sel <= PORT_INDEX;
		host_wr <= 1'b1;
		host_wdata <= {1'b0, idx};
	endtask

	// Data port write; released data shows the inverse
	task automatic put_byte(input logic [6:0] idx, input logic [7:0] val);
		put_index(idx);
		@(posedge ref_clk);
		host_sel <= PORT_DATA;
		host_wdata <= val;
		@(posedge ref_clk);
		host_wr <= 1'b0;
		host_wdata <= ~val;
	endtask

	// Data port read, sampled once the read edge has landed
	task automatic get_byte(input logic [6:0] idx, output logic [7:0] val);
		put_index(idx);
		@(posedge ref_clk);
		host_sel <= PORT_DATA;
		host_wr <= 1'b0;
		host_rd <= 1'b1;
		host_wdata <= {1'b1, ~idx};
		@(posedge ref_clk);
		host_rd <= 1'b0;
		#1;
		val = host_rdata_q;
	endtask
endmodule

`default_nettype wire

// ---- rtc_pkg.sv ----
package rtc_pkg;

	// Register indices in the standard RAM space
	localparam logic [6:0] IDX_ELAPSED_S   = 7'h00;
	localparam logic [6:0] IDX_ALARM_S     = 7'h01;
	localparam logic [6:0] IDX_ELAPSED_M   = 7'h02;
	localparam logic [6:0] IDX_ALARM_M     = 7'h03;
	localparam logic [6:0] IDX_HOURS       = 7'h04;
	localparam logic [6:0] IDX_ALARM_H     = 7'h05;
	localparam logic [6:0] IDX_WEEKDAY     = 7'h06;
	localparam logic [6:0] IDX_DATE        = 7'h07;
	localparam logic [6:0] IDX_CALENDAR_M  = 7'h08;
	localparam logic [6:0] IDX_YEAR        = 7'h09;
	localparam logic [6:0] IDX_CTRL_A      = 7'h0a;
	localparam logic [6:0] IDX_CTRL_B      = 7'h0b;
	localparam logic [6:0] IDX_CTRL_C      = 7'h0c;
	localparam logic [6:0] IDX_CTRL_D      = 7'h0d;
	localparam logic [6:0] IDX_RAM_FIRST   = 7'h0e;

	// Reset values
	localparam logic [7:0] TIME_RESET      = 8'h00;
	localparam logic [6:0] CTRL_A_RESET    = 7'h20;
	localparam logic [7:0] CTRL_B_RESET    = 8'h00;

	// Field positions
	localparam int CTRL_B_SET_BIT          = 7;
	localparam int CTRL_B_RSVD_BIT         = 3;
	localparam int CTRL_B_DATA_MODE_BIT    = 2;
	localparam int CTRL_B_HOUR_MODE_BIT    = 1;
	localparam int CTRL_C_ALARM_BIT        = 5;
	localparam int CTRL_C_UPDATE_BIT       = 4;
	localparam int CTRL_D_VALID_BIT        = 7;
	localparam int HOUR_PM_BIT             = 7;

	// Divider chain code that lets time advance
	localparam logic [2:0] DIVIDER_NORMAL  = 3'b010;

	// Don't-care code in alarm bits 7:6
	localparam logic [1:0] ALARM_ANY       = 2'b11;

	// Counter limits, binary
	localparam logic [6:0] SEC_MAX         = 7'd59;
	localparam logic [6:0] HOUR24_MAX      = 7'd23;
	localparam logic [6:0] HOUR12_MAX      = 7'd12;
	localparam logic [6:0] HOUR12_LAST_AM  = 7'd11;
	localparam logic [6:0] WEEKDAY_MAX     = 7'd7;
	localparam logic [6:0] MONTH_MAX       = 7'd12;
	localparam logic [6:0] YEAR_MAX        = 7'd99;
	localparam logic [6:0] FEBRUARY        = 7'd2;

	// Host port selects
	localparam logic PORT_INDEX            = 1'b0;
	localparam logic PORT_DATA             = 1'b1;

	// Stored value to plain binary
	function automatic logic [6:0] to_bin(input logic [7:0] v, input logic bcd);
		logic [6:0] t;
		t = 7'({3'b000, v[7:4]} * 7'd10);
		return bcd ? 7'(t + {3'b000, v[3:0]}) : v[6:0];
	endfunction

	// Plain binary to stored value
	function automatic logic [7:0] from_bin(input logic [6:0] b, input logic bcd);
		logic [6:0] tens;
		logic [6:0] ones;
		tens = b / 7'd10;
		ones = b % 7'd10;
		return bcd ? {tens[3:0], ones[3:0]} : {1'b0, b};
	endfunction

endpackage

// ---- rtc_tcr_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtc_tcr_asserts
	import rtc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       host_sel,
	input  wire logic       host_wr,
	input  wire logic       host_rd,
	input  wire logic [7:0] host_wdata,
	input  wire logic [7:0] host_rdata_q,
	input  wire logic       second_tick,
	input  wire logic       alarm_event_q,
	input  wire logic       update_event_q
);
	logic [6:0] idx_q;
	logic       seen_d_q;

	// Shadow of the index port
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			idx_q <= 7'h00;
		else if (host_wr && !host_sel)
			idx_q <= host_wdata[6:0];

	// Set once the valid byte has been read
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			seen_d_q <= 1'b0;
		else if (host_rd && host_sel && idx_q == IDX_CTRL_D)
			seen_d_q <= 1'b1;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_rd(logic [6:0] i);
		host_rd && host_sel && idx_q == i;
	endsequence
	sequence s_stepped;
		$past(second_tick, 2) && $past(update_event_q);
	endsequence

	a_update_cause: assert property (update_event_q |-> $past(second_tick))
		else $error("update pulse without a tick");
	a_update_pulse: assert property (update_event_q |=> !update_event_q)
		else $error("update pulse longer than one cycle");
	a_alarm_cause: assert property (alarm_event_q |-> s_stepped)
		else $error("alarm pulse not two cycles after a tick");
	a_alarm_pulse: assert property (alarm_event_q |=> !alarm_event_q)
		else $error("alarm pulse longer than one cycle");
	a_event_apart: assert property (!(alarm_event_q && update_event_q))
		else $error("alarm and update pulses overlap");
	a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata_q))
		else $error("read data changed without a read");
	a_ctrl_c_bits: assert property (s_rd(IDX_CTRL_C) |=> (host_rdata_q & 8'hcf) == 8'h00)
		else $error("unused flag bits read as one");
	a_ctrl_d_low: assert property (s_rd(IDX_CTRL_D) |=> host_rdata_q[6:0] == 7'h00)
		else $error("valid byte low bits not zero");
	a_ctrl_d_valid: assert property (s_rd(IDX_CTRL_D) ##0 seen_d_q |=> host_rdata_q[7])
		else $error("valid bit not set after first read");
endmodule

bind rtc_time_calendar_registers rtc_tcr_asserts chk (.ref_clk, .rst, .host_sel, .host_wr,
	.host_rd, .host_wdata, .host_rdata_q, .second_tick, .alarm_event_q, .update_event_q);

`default_nettype wire

// ---- rtc_time_calendar_registers.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE_01 - seconds, minutes wrap at 59 or 3B
// RULE_02 - alarms take same ranges as counters
// RULE_03 - alarm top bits 11 match anything
// RULE_04 - 12-hour: 01-12 am, 81-92 pm
// RULE_05 - 24-hour hours run 00 to 23/17
// RULE_06 - weekday cycles 01 to 07
// RULE_07 - date runs 01 to 31/1F
// RULE_08 - month runs 01 to 12/0C
// RULE_09 - year runs 00 to 99/63, wraps
// RULE_10 - three bytes overlay RAM at programmable index
// RULE_11 - control C read-only, writes ignored
// RULE_12 - control D read-only, reset by power-up only
// RULE_13 - data-mode bit: 0 BCD, 1 binary
// RULE_14 - hour-mode bit: 0 12-hour, 1 24-hour
// RULE_15 - host writes index, then data port
// RULE_16 - alarm event when time matches alarms
// RULE_17 - counters carry; date follows month, leap year
module rtc_time_calendar_registers
	import rtc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       host_sel,
	input  wire logic       host_wr,
	input  wire logic       host_rd,
	input  wire logic [7:0] host_wdata,
	output logic      [7:0] host_rdata_q,
	input  wire logic       second_tick,
	input  wire logic       alarm_date_en,
	input  wire logic [6:0] alarm_date_idx,
	input  wire logic       alarm_month_en,
	input  wire logic [6:0] alarm_month_idx,
	input  wire logic       century_en,
	input  wire logic [6:0] century_idx,
	output logic            alarm_event_q,
	output logic            update_event_q
);
	localparam int RAM_DEPTH = 128;

	logic [6:0] index_q;
	logic [7:0] elapsed_s_field;
	logic [7:0] alarm_s_field;
	logic [7:0] elapsed_m_field;
	logic [7:0] alarm_m_field;
	logic [7:0] hours_count;
	logic [7:0] alarm_h_field;
	logic [7:0] weekday_count;
	logic [7:0] date_count;
	logic [7:0] calendar_m_field;
	logic [7:0] year_count;
	logic [6:0] ctrl_a_reg;
	logic [7:0] ctrl_b_reg;
	logic [7:0] ctrl_c_flags;
	logic       ctrl_d_valid;
	logic [7:0] alarm_date_field;
	logic [7:0] alarm_calendar_m_field;
	logic [7:0] hundred_years_count;
	logic [7:0] ram_q [RAM_DEPTH];

	logic       data_wr;
	logic       data_rd;
	logic       bcd;
	logic       h24;
	logic       running;
	logic       advance;
	logic       sel_date_alarm;
	logic       sel_month_alarm;
	logic       sel_century;
	logic       is_ram;
	logic [7:0] rd_value;

	// Host port decode; data writes wait until the valid byte has been read once (that first read returns 00)
	assign data_wr = host_wr && (host_sel == PORT_DATA) && ctrl_d_valid; // [RULE_15]
	assign data_rd = host_rd && (host_sel == PORT_DATA); // [RULE_15]
	assign bcd     = !ctrl_b_reg[CTRL_B_DATA_MODE_BIT]; // [RULE_13]
	assign h24     = ctrl_b_reg[CTRL_B_HOUR_MODE_BIT]; // [RULE_14]
	assign running = (ctrl_a_reg[6:4] == DIVIDER_NORMAL) && !ctrl_b_reg[CTRL_B_SET_BIT];
	assign advance = second_tick && running;

	// Programmable overlay bytes take over RAM at their index when enabled
	assign sel_date_alarm  = alarm_date_en && (index_q >= IDX_RAM_FIRST)
		&& (index_q == alarm_date_idx); // [RULE_10]
	assign sel_month_alarm = alarm_month_en && (index_q >= IDX_RAM_FIRST)
		&& (index_q == alarm_month_idx); // [RULE_10]
	assign sel_century     = century_en && (index_q >= IDX_RAM_FIRST)
		&& (index_q == century_idx); // [RULE_10]
	assign is_ram = (index_q >= IDX_RAM_FIRST) && !sel_date_alarm
		&& !sel_month_alarm && !sel_century;

	// Counter step units
	logic [7:0] sec_nxt;
	logic [7:0] min_nxt;
	logic [7:0] hr_nxt;
	logic [7:0] wd_nxt;
	logic [7:0] date_nxt;
	logic [7:0] mon_nxt;
	logic [7:0] yr_nxt;
	logic       sec_wrap;
	logic       min_wrap;
	logic       hr_wrap;
	logic       date_wrap;
	logic       mon_wrap;
	logic [6:0] hr_lo;
	logic [6:0] hr_hi;
	logic [6:0] date_hi;
	logic [6:0] mon_bin;
	logic [6:0] yr_bin;
	logic [6:0] hr_bin;
	logic       day_carry;
	logic [7:0] hr_next_full;

	// Seconds and minutes
	rtc_count_step u_sec (
		.cur  (elapsed_s_field),
		.lo   (7'd0),
		.hi   (SEC_MAX), // [RULE_01]
		.bcd  (bcd),
		.nxt  (sec_nxt),
		.wrap (sec_wrap)
	);
	rtc_count_step u_min (
		.cur  (elapsed_m_field),
		.lo   (7'd0),
		.hi   (SEC_MAX), // [RULE_01]
		.bcd  (bcd),
		.nxt  (min_nxt),
		.wrap (min_wrap)
	);

	// Hours count on the low seven bits; the pm bit is handled below
	assign hr_lo = h24 ? 7'd0 : 7'd1;
	assign hr_hi = h24 ? HOUR24_MAX : HOUR12_MAX; // [RULE_04] [RULE_05]
	assign hr_bin = to_bin({1'b0, hours_count[6:0]}, bcd);
	rtc_count_step u_hour (
		.cur  ({1'b0, hours_count[6:0]}),
		.lo   (hr_lo),
		.hi   (hr_hi),
		.bcd  (bcd),
		.nxt  (hr_nxt),
		.wrap (hr_wrap)
	);

	// In 12-hour mode the pm bit flips on leaving 11; day ends after 11 pm
	always_comb
	begin
		if (h24)
		begin
			hr_next_full = hr_nxt; // [RULE_05]
			day_carry    = hr_wrap;
		end
		else
		begin
			hr_next_full = {hours_count[HOUR_PM_BIT] ^ (hr_bin == HOUR12_LAST_AM),
				hr_nxt[6:0]}; // [RULE_04]
			day_carry    = hours_count[HOUR_PM_BIT] && (hr_bin == HOUR12_LAST_AM);
		end
	end

	// Weekday
	rtc_count_step u_weekday (
		.cur  (weekday_count),
		.lo   (7'd1),
		.hi   (WEEKDAY_MAX), // [RULE_06]
		.bcd  (bcd),
		.nxt  (wd_nxt),
		.wrap ()
	);

	// Month length from month and two-digit year
	assign mon_bin = to_bin(calendar_m_field, bcd);
	assign yr_bin  = to_bin(year_count, bcd);
	always_comb
	begin
		case (mon_bin)
			7'd4, 7'd6, 7'd9, 7'd11: date_hi = 7'd30;
			FEBRUARY:                date_hi = (yr_bin[1:0] == 2'b00) ? 7'd29 : 7'd28; // [RULE_17]
			default:                 date_hi = 7'd31; // [RULE_07]
		endcase
	end

	// Date, month and year
	rtc_count_step u_date (
		.cur  (date_count),
		.lo   (7'd1),
		.hi   (date_hi), // [RULE_07]
		.bcd  (bcd),
		.nxt  (date_nxt),
		.wrap (date_wrap)
	);
	rtc_count_step u_month (
		.cur  (calendar_m_field),
		.lo   (7'd1),
		.hi   (MONTH_MAX), // [RULE_08]
		.bcd  (bcd),
		.nxt  (mon_nxt),
		.wrap (mon_wrap)
	);
	rtc_count_step u_year (
		.cur  (year_count),
		.lo   (7'd0),
		.hi   (YEAR_MAX), // [RULE_09]
		.bcd  (bcd),
		.nxt  (yr_nxt),
		.wrap ()
	);

	// Alarm compare fields
	logic hit_s;
	logic hit_m;
	logic hit_h;
	rtc_alarm_field u_hit_s (
		.count (elapsed_s_field),
		.alarm (alarm_s_field), // [RULE_03]
		.hit   (hit_s)
	);
	rtc_alarm_field u_hit_m (
		.count (elapsed_m_field),
		.alarm (alarm_m_field),
		.hit   (hit_m)
	);
	rtc_alarm_field u_hit_h (
		.count (hours_count),
		.alarm (alarm_h_field),
		.hit   (hit_h)
	);

	// Index port
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			index_q <= 7'h00;
		else if (host_wr && (host_sel == PORT_INDEX))
			index_q <= host_wdata[6:0]; // [RULE_15]
	end

	// Time and calendar counters; a host write wins over the tick for its byte
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			elapsed_s_field  <= TIME_RESET;
			elapsed_m_field  <= TIME_RESET;
			hours_count      <= TIME_RESET;
			weekday_count    <= TIME_RESET;
			date_count       <= TIME_RESET;
			calendar_m_field <= TIME_RESET;
			year_count       <= TIME_RESET;
		end
		else
		begin
			if (data_wr && index_q == IDX_ELAPSED_S)
				elapsed_s_field <= host_wdata;
			else if (advance)
				elapsed_s_field <= sec_nxt; // [RULE_01]
			if (data_wr && index_q == IDX_ELAPSED_M)
				elapsed_m_field <= host_wdata;
			else if (advance && sec_wrap)
				elapsed_m_field <= min_nxt; // [RULE_01] [RULE_17]
			if (data_wr && index_q == IDX_HOURS)
				hours_count <= host_wdata;
			else if (advance && sec_wrap && min_wrap)
				hours_count <= hr_next_full; // [RULE_17]
			if (data_wr && index_q == IDX_WEEKDAY)
				weekday_count <= host_wdata;
			else if (advance && sec_wrap && min_wrap && day_carry)
				weekday_count <= wd_nxt; // [RULE_06]
			if (data_wr && index_q == IDX_DATE)
				date_count <= host_wdata;
			else if (advance && sec_wrap && min_wrap && day_carry)
				date_count <= date_nxt; // [RULE_17]
			if (data_wr && index_q == IDX_CALENDAR_M)
				calendar_m_field <= host_wdata;
			else if (advance && sec_wrap && min_wrap && day_carry && date_wrap)
				calendar_m_field <= mon_nxt; // [RULE_08]
			if (data_wr && index_q == IDX_YEAR)
				year_count <= host_wdata;
			else if (advance && sec_wrap && min_wrap && day_carry && date_wrap && mon_wrap)
				year_count <= yr_nxt; // [RULE_09] [RULE_17]
		end
	end

	// Alarm and overlay bytes, stored as written in the current format
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			alarm_s_field          <= TIME_RESET;
			alarm_m_field          <= TIME_RESET;
			alarm_h_field          <= TIME_RESET;
			alarm_date_field       <= TIME_RESET;
			alarm_calendar_m_field <= TIME_RESET;
			hundred_years_count    <= TIME_RESET;
		end
		else if (data_wr)
		begin
			if (index_q == IDX_ALARM_S)
				alarm_s_field <= host_wdata; // [RULE_02]
			if (index_q == IDX_ALARM_M)
				alarm_m_field <= host_wdata; // [RULE_02]
			if (index_q == IDX_ALARM_H)
				alarm_h_field <= host_wdata; // [RULE_02]
			if (sel_date_alarm)
				alarm_date_field <= host_wdata; // [RULE_10]
			if (sel_month_alarm)
				alarm_calendar_m_field <= host_wdata; // [RULE_10]
			if (sel_century)
				hundred_years_count <= host_wdata; // [RULE_10]
		end
	end

	// General RAM; kept across resets, no reset value
	always_ff @(posedge ref_clk)
	begin
		if (data_wr && is_ram)
			ram_q[index_q] <= host_wdata;
	end

	// Control A and B; A holds its reset value until the valid bit is set
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_a_reg <= CTRL_A_RESET;
			ctrl_b_reg <= CTRL_B_RESET;
		end
		else
		begin
			if (!ctrl_d_valid)
				ctrl_a_reg <= CTRL_A_RESET;
			else if (data_wr && index_q == IDX_CTRL_A)
				ctrl_a_reg <= host_wdata[6:0];
			if (data_wr && index_q == IDX_CTRL_B)
			begin
				ctrl_b_reg <= host_wdata; // [RULE_13] [RULE_14]
				ctrl_b_reg[CTRL_B_RSVD_BIT] <= 1'b0;
			end
		end
	end

	// Event pulses: update end on the same edge as the step, alarm check on the new time
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			update_event_q <= 1'b0;
			alarm_event_q  <= 1'b0;
		end
		else
		begin
			update_event_q <= advance;
			alarm_event_q  <= update_event_q && hit_s && hit_m && hit_h; // [RULE_16]
		end
	end

	// Control C flags: set by events, cleared by a data read at its index; set wins
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ctrl_c_flags <= 8'h00;
		else
		begin
			if (data_rd && index_q == IDX_CTRL_C)
				ctrl_c_flags <= 8'h00; // [RULE_11]
			if (update_event_q)
				ctrl_c_flags[CTRL_C_UPDATE_BIT] <= 1'b1;
			if (update_event_q && hit_s && hit_m && hit_h)
				ctrl_c_flags[CTRL_C_ALARM_BIT] <= 1'b1; // [RULE_16]
		end
	end

	// Control D valid bit: cleared only by power-up reset, set once read
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ctrl_d_valid <= 1'b0; // [RULE_12]
		else if (data_rd && index_q == IDX_CTRL_D)
			ctrl_d_valid <= 1'b1; // [RULE_12]
	end

	// Read multiplexer for the data port
	always_comb
	begin
		rd_value = 8'h00;
		if (sel_date_alarm)
			rd_value = alarm_date_field;
		else if (sel_month_alarm)
			rd_value = alarm_calendar_m_field;
		else if (sel_century)
			rd_value = hundred_years_count;
		else if (is_ram)
			rd_value = ram_q[index_q];
		else
		begin
			case (index_q)
				IDX_ELAPSED_S:  rd_value = elapsed_s_field;
				IDX_ALARM_S:    rd_value = alarm_s_field;
				IDX_ELAPSED_M:  rd_value = elapsed_m_field;
				IDX_ALARM_M:    rd_value = alarm_m_field;
				IDX_HOURS:      rd_value = hours_count;
				IDX_ALARM_H:    rd_value = alarm_h_field;
				IDX_WEEKDAY:    rd_value = weekday_count;
				IDX_DATE:       rd_value = date_count;
				IDX_CALENDAR_M: rd_value = calendar_m_field;
				IDX_YEAR:       rd_value = year_count;
				IDX_CTRL_A:     rd_value = {1'b0, ctrl_a_reg};
				IDX_CTRL_B:     rd_value = ctrl_b_reg;
				IDX_CTRL_C:     rd_value = ctrl_c_flags; // [RULE_11]
				IDX_CTRL_D:     rd_value = {ctrl_d_valid, 7'h00};
				default:        rd_value = 8'h00;
			endcase
		end
	end

	// Read data register, loaded on a read of either port
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			host_rdata_q <= 8'h00;
		else if (host_rd)
			host_rdata_q <= (host_sel == PORT_DATA) ? rd_value : {1'b0, index_q};
	end
endmodule

`default_nettype wire

// ---- test_rtc_time_calendar_registers.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_rtc_time_calendar_registers
	import rtc_pkg::*;
;
	logic       ref_clk = 1'b0;
	logic       rst = 1'b1;
	logic       host_sel;
	logic       host_wr;
	logic       host_rd;
	logic [7:0] host_wdata;
	logic [7:0] host_rdata_q;
	logic       second_tick = 1'b0;
	logic [2:0] ov_en = 3'b000;
	logic [6:0] ov_idx [3] = '{7'h0e, 7'h47, 7'h7f};
	logic       alarm_event_q;
	logic       update_event_q;
	int         errors = 0;
	int         total_checks = 0;

	always #2.5 ref_clk = ~ref_clk;

	rtc_host_model host (.ref_clk, .host_rdata_q, .host_sel, .host_wr, .host_rd, .host_wdata);

	rtc_time_calendar_registers DUT (.ref_clk, .rst, .host_sel, .host_wr, .host_rd,
		.host_wdata, .host_rdata_q, .second_tick, .alarm_date_en(ov_en[0]),
		.alarm_date_idx(ov_idx[0]), .alarm_month_en(ov_en[1]), .alarm_month_idx(ov_idx[1]),
		.century_en(ov_en[2]), .century_idx(ov_idx[2]), .alarm_event_q, .update_event_q);

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			errors++;
		end
	endtask

	task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		host.get_byte(idx, v);
		check($sformatf("byte %h", idx), v, exp);
	endtask

	// One second step, then update and alarm pulses in their cycles
	task automatic tick(input logic alarm, input logic run = 1'b1);
		@(posedge ref_clk);
		second_tick <= 1'b1;
		@(posedge ref_clk);
		second_tick <= 1'b0;
		#1;
		check("update pulse", {7'h00, update_event_q}, {7'h00, run});
		@(posedge ref_clk);
		#1;
		check("alarm pulse", {7'h00, alarm_event_q}, {7'h00, alarm});
	endtask

	// Reset values, write lock until valid byte read
	task automatic t_reset();
		host.put_byte(IDX_ELAPSED_S, 8'h33);
		host.put_byte(IDX_CTRL_A, 8'h00);
		rd(IDX_CTRL_D, 8'h00);
		for (int i = 0; i < 10; i++)
			rd(7'(i), TIME_RESET);
		rd(IDX_CTRL_A, {1'b0, CTRL_A_RESET});
		rd(IDX_CTRL_B, CTRL_B_RESET);
		rd(IDX_CTRL_C, 8'h00);
		rd(IDX_CTRL_D, 8'h80);
		host.put_byte(IDX_CTRL_C, 8'hff);
		host.put_byte(IDX_CTRL_D, 8'h00);
		rd(IDX_CTRL_C, 8'h00);
		rd(IDX_CTRL_D, 8'h80);
	endtask

	// Every counter at its top value wraps on one step
	task automatic t_wrap(input logic bin);
		logic [7:0] top [10];
		if (bin)
			top = '{8'h3b, 8'h00, 8'h3b, 8'h00, 8'h17, 8'h00, 8'h07, 8'h1f, 8'h0c, 8'h63};
		else
			top = '{8'h59, 8'h00, 8'h59, 8'h00, 8'h23, 8'h00, 8'h07, 8'h31, 8'h12, 8'h99};
		host.put_byte(IDX_CTRL_B, {5'h00, bin, 2'b10});
		for (int i = 0; i < 10; i++)
			host.put_byte(7'(i), top[i]);
		tick(1'b1);
		for (int i = 0; i < 10; i++)
			rd(7'(i), (i == 6 || i == 7 || i == 8) ? 8'h01 : 8'h00);
		rd(IDX_CTRL_C, 8'h30);
		host.put_byte(IDX_ELAPSED_S, 8'h09);
		tick(1'b0);
		rd(IDX_ELAPSED_S, bin ? 8'h0a : 8'h10);
	endtask

	// Don't-care alarm fields, then a seconds miss
	task automatic t_alarm();
		host.put_byte(IDX_CTRL_B, 8'h02);
		host.put_byte(IDX_ALARM_S, 8'h05);
		host.put_byte(IDX_ALARM_M, 8'hc0);
		host.put_byte(IDX_ALARM_H, 8'hc7);
		host.put_byte(IDX_ELAPSED_M, 8'h30);
		host.put_byte(IDX_HOURS, 8'h12);
		host.put_byte(IDX_ELAPSED_S, 8'h04);
		tick(1'b1);
		rd(IDX_CTRL_C, 8'h30);
		host.put_byte(IDX_ELAPSED_S, 8'h05);
		tick(1'b0);
		rd(IDX_CTRL_C, 8'h10);
		host.put_byte(IDX_CTRL_B, 8'h82);
		tick(1'b0, 1'b0);
		host.put_byte(IDX_CTRL_B, 8'h02);
		host.put_byte(IDX_CTRL_A, 8'h00);
		rd(IDX_CTRL_A, 8'h00);
		tick(1'b0, 1'b0);
		rd(IDX_ELAPSED_S, 8'h06);
		host.put_byte(IDX_CTRL_A, {1'b0, CTRL_A_RESET});
	endtask

	// Twelve-hour steps: mode byte, hour before, hour after
	task automatic t_hours12();
		logic [7:0] tab [5][3] = '{'{8'h00, 8'h11, 8'h92}, '{8'h00, 8'h92, 8'h81},
			'{8'h00, 8'h91, 8'h12}, '{8'h04, 8'h0b, 8'h8c}, '{8'h04, 8'h8c, 8'h81}};
		for (int i = 0; i < 5; i++)
		begin
			host.put_byte(IDX_CTRL_B, tab[i][0]);
			host.put_byte(IDX_ELAPSED_M, tab[i][0][2] ? 8'h3b : 8'h59);
			host.put_byte(IDX_HOURS, tab[i][1]);
			host.put_byte(IDX_ELAPSED_S, tab[i][0][2] ? 8'h3b : 8'h59);
			tick(1'b0);
			rd(IDX_HOURS, tab[i][2]);
		end
	endtask

	// Overlay bytes hide the RAM byte beneath them
	task automatic t_overlay();
		for (int k = 0; k < 3; k++)
		begin
			@(posedge ref_clk);
			ov_en[k] <= 1'b1;
			host.put_byte(ov_idx[k], 8'h40 + 8'(k));
			ov_en[k] <= 1'b0;
			host.put_byte(ov_idx[k], 8'h77);
			ov_en[k] <= 1'b1;
			rd(ov_idx[k], 8'h40 + 8'(k));
			@(posedge ref_clk);
			ov_en[k] <= 1'b0;
			rd(ov_idx[k], 8'h77);
		end
	endtask

	// Power loss mid-run: registers and valid bit start over, writes locked again
	task automatic t_power_loss();
		host.put_byte(IDX_ELAPSED_S, 8'h21);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		host.put_byte(IDX_ELAPSED_S, 8'h21);
		rd(IDX_CTRL_D, 8'h00);
		rd(IDX_ELAPSED_S, TIME_RESET);
		rd(IDX_CTRL_B, CTRL_B_RESET);
		rd(IDX_CTRL_D, 8'h80);
	endtask

	// Hang guard
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		errors++;
		summarize();
	end

	// Main sequence
	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_wrap(1'b0);
		t_wrap(1'b1);
		t_alarm();
		t_hours12();
		t_overlay();
		t_power_loss();
		summarize();
	end
endmodule

`default_nettype wire
